// ==== hw/spfc_cfg.svh ====
`ifndef SPFC_CFG_SVH
`define SPFC_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SPFC_CSR_INDEX      8'h37
`define SPFC_CSR_BYTE_ADDR  32'h0000_00DC
`define SPFC_CSR_RESET      8'h00
`define SPFC_BIT_IE         7
`define SPFC_BIT_BUSY       6
`define SPFC_CMD_MSB        4

// ----------------------------------------------------------------
// command patterns, lower five bits
// ----------------------------------------------------------------
`define SPFC_PAT_REEN       5'h11
`define SPFC_PAT_LOCK       5'h09
`define SPFC_PAT_PWRITE     5'h05
`define SPFC_PAT_PERASE     5'h03
`define SPFC_PAT_FILL       5'h01

// ----------------------------------------------------------------
// flash layout
// ----------------------------------------------------------------
`define SPFC_BOOT_START_3   14'h3F00
`define SPFC_BOOT_START_2   14'h3E00
`define SPFC_BOOT_START_1   14'h3C00
`define SPFC_BOOT_START_0   14'h3800
`define SPFC_HALTING_REGION_START     14'h3800
`define SPFC_Z_PAGE_MSB     14
`define SPFC_Z_PAGE_LSB     7
`define SPFC_Z_WORD_MSB     6
`define SPFC_Z_WORD_LSB     1
`define SPFC_WORD_ZERO      6'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPFC_WIN_CYCLES     3'h4
// load window of three cycles: counter values 4..2
`define SPFC_LPM_MIN_CNT    3'h2
`define SPFC_CLK_PERIOD_NS  10
`define SPFC_PROG_MIN_NS    3700000
`define SPFC_PROG_MAX_NS    4500000
`define SPFC_PROG_CYCLES    ((`SPFC_PROG_MIN_NS + `SPFC_CLK_PERIOD_NS - 1) / `SPFC_CLK_PERIOD_NS)

`endif

// ==== hw/spfc_pkg.sv ====
package spfc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WINDOW,
    ST_BUSY
  } spfc_state_t;
endpackage

// ==== hw/spfc_ctrl.sv ====
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "spfc_cfg.svh"

module spfc_ctrl #(
  parameter int PROG_CYCLES = `SPFC_PROG_CYCLES,
  parameter int CNT_W       = 20
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // processor core
  input  wire logic        spm_strobe_in,
  input  wire logic        lpm_strobe_in,
  input  wire logic [15:0] zptr_in,
  input  wire logic [7:0]  data_low_in,
  input  wire logic [7:0]  data_high_in,
  input  wire logic        global_irq_enable_in,
  input  wire logic [1:0]  boot_size_select_in,
  output logic             store_ready_irq_out,
  output logic             cpu_halt_out,
  output logic             lpm_special_out,
  output logic             lpm_fuse_sel_out,
  // flash array
  output logic             rww_block_out,
  output logic             flash_busy_out,
  output logic             buf_write_out,
  output logic      [5:0]  buf_word_index_out,
  output logic      [15:0] buf_data_out,
  output logic             buf_discard_out,
  output logic             page_erase_out,
  output logic             page_write_out,
  output logic      [7:0]  page_index_out,
  output logic             lock_write_out,
  output logic      [7:0]  lock_data_out,
  output logic      [13:0] boot_start_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic pat_valid(input logic [4:0] p);
    pat_valid = (p == `SPFC_PAT_REEN) || (p == `SPFC_PAT_LOCK) ||
                (p == `SPFC_PAT_PWRITE) || (p == `SPFC_PAT_PERASE) ||
                (p == `SPFC_PAT_FILL);
  endfunction

  function automatic logic in_rww(input logic [7:0] page);
    in_rww = ({page, `SPFC_WORD_ZERO} < `SPFC_HALTING_REGION_START);
  endfunction

  function automatic logic [13:0] boot_start_f(input logic [1:0] sz);
    if (sz == 2'h3) begin
      boot_start_f = `SPFC_BOOT_START_3;
    end else if (sz == 2'h2) begin
      boot_start_f = `SPFC_BOOT_START_2;
    end else if (sz == 2'h1) begin
      boot_start_f = `SPFC_BOOT_START_1;
    end else begin
      boot_start_f = `SPFC_BOOT_START_0;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spfc_pkg::spfc_state_t state_r;
  logic [4:0]       cmd_r;
  logic [2:0]       win_r;
  logic [CNT_W-1:0] prog_r;
  logic             ie_r;
  logic             busy_flag_r;
  logic             filling_r;
  logic             wr_pend_r;
  logic             rd_wait_r;
  logic             rd_hit_r;
  logic             halt_r;

  logic       addr_ok;
  logic       addr_hit;
  logic [7:0] wdat;
  logic       arm;
  logic       take;
  logic [7:0] zpage;
  logic [7:0] csr_rd;

  assign addr_ok  = hsel_in & hready_in & htrans_in[1];
  assign addr_hit = (haddr_in == `SPFC_CSR_BYTE_ADDR);
  assign wdat     = hwdata_in[7:0];
  assign zpage    = zptr_in[`SPFC_Z_PAGE_MSB:`SPFC_Z_PAGE_LSB];
  assign csr_rd   = {ie_r, busy_flag_r, 1'b0, cmd_r};
  // commands are ignored while an operation runs
  assign arm      = wr_pend_r & pat_valid(wdat[4:0]) & (state_r != spfc_pkg::ST_BUSY);
  assign take     = spm_strobe_in & (state_r == spfc_pkg::ST_WINDOW) & ~arm;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // reads take one wait state so a preceding write is always visible
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend_r     <= 1'b0;
      rd_wait_r     <= 1'b0;
      rd_hit_r      <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ok & hwrite_in & addr_hit;
      if (addr_ok & ~hwrite_in) begin
        rd_wait_r     <= 1'b1;
        rd_hit_r      <= addr_hit;
        hreadyout_out <= 1'b0;
      end else if (rd_wait_r) begin
        rd_wait_r     <= 1'b0;
        hreadyout_out <= 1'b1;
        hrdata_out    <= rd_hit_r ? {24'h00_0000, csr_rd} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // register write
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ie_r <= 1'(`SPFC_CSR_RESET >> `SPFC_BIT_IE);
    end else if (wr_pend_r) begin
      ie_r <= wdat[`SPFC_BIT_IE];
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= spfc_pkg::ST_IDLE;
      cmd_r   <= 5'h00;
      win_r   <= 3'h0;
      prog_r  <= '0;
    end else begin
      case (state_r)
        spfc_pkg::ST_IDLE: begin
          if (arm) begin
            cmd_r   <= wdat[4:0];
            win_r   <= `SPFC_WIN_CYCLES;
            state_r <= spfc_pkg::ST_WINDOW;
          end
        end
        spfc_pkg::ST_WINDOW: begin
          if (arm) begin
            cmd_r <= wdat[4:0];
            win_r <= `SPFC_WIN_CYCLES;
          end else if (take) begin
            if ((cmd_r == `SPFC_PAT_PERASE) || (cmd_r == `SPFC_PAT_PWRITE) ||
                (cmd_r == `SPFC_PAT_LOCK)) begin
              prog_r  <= CNT_W'(PROG_CYCLES - 1);
              state_r <= spfc_pkg::ST_BUSY;
            end else begin
              cmd_r   <= 5'h00;
              state_r <= spfc_pkg::ST_IDLE;
            end
          end else if (win_r == 3'h1) begin
            cmd_r   <= 5'h00;
            state_r <= spfc_pkg::ST_IDLE;
          end else begin
            win_r <= win_r - 3'h1;
          end
        end
        spfc_pkg::ST_BUSY: begin
          if (prog_r == '0) begin
            cmd_r   <= 5'h00;
            state_r <= spfc_pkg::ST_IDLE;
          end else begin
            prog_r <= prog_r - CNT_W'(1);
          end
        end
        default: begin
          state_r <= spfc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // region busy and halt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      busy_flag_r <= 1'b0;
    end else if (take & ((cmd_r == `SPFC_PAT_PERASE) || (cmd_r == `SPFC_PAT_PWRITE)) &
                 in_rww(zpage)) begin
      busy_flag_r <= 1'b1;
    end else if (take & ((cmd_r == `SPFC_PAT_FILL) || (cmd_r == `SPFC_PAT_REEN))) begin
      busy_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      halt_r <= 1'b0;
    end else if (take & ((cmd_r == `SPFC_PAT_PERASE) || (cmd_r == `SPFC_PAT_PWRITE)) &
                 ~in_rww(zpage)) begin
      halt_r <= 1'b1;
    end else if ((state_r == spfc_pkg::ST_BUSY) && (prog_r == '0)) begin
      halt_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rww_block_out  <= 1'b0;
      cpu_halt_out   <= 1'b0;
      flash_busy_out <= 1'b0;
    end else begin
      rww_block_out  <= busy_flag_r;
      cpu_halt_out   <= halt_r;
      flash_busy_out <= (state_r == spfc_pkg::ST_BUSY);
    end
  end

  // ----------------------------------------------------------------
  // page buffer and flash commands
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      filling_r       <= 1'b0;
      buf_discard_out <= 1'b0;
    end else begin
      buf_discard_out <= 1'b0;
      if (arm & (wdat[4:0] == `SPFC_PAT_REEN) & filling_r) begin
        filling_r       <= 1'b0;
        buf_discard_out <= 1'b1;
      end else if (take & (cmd_r == `SPFC_PAT_FILL)) begin
        filling_r <= 1'b1;
      end else if (take & (cmd_r == `SPFC_PAT_PWRITE)) begin
        filling_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      buf_write_out      <= 1'b0;
      page_erase_out     <= 1'b0;
      page_write_out     <= 1'b0;
      lock_write_out     <= 1'b0;
      buf_word_index_out <= 6'h00;
      buf_data_out       <= 16'h0000;
      page_index_out     <= 8'h00;
      lock_data_out      <= 8'h00;
    end else begin
      buf_write_out  <= take & (cmd_r == `SPFC_PAT_FILL);
      page_erase_out <= take & (cmd_r == `SPFC_PAT_PERASE);
      page_write_out <= take & (cmd_r == `SPFC_PAT_PWRITE);
      lock_write_out <= take & (cmd_r == `SPFC_PAT_LOCK);
      if (take) begin
        buf_word_index_out <= zptr_in[`SPFC_Z_WORD_MSB:`SPFC_Z_WORD_LSB];
        buf_data_out       <= {data_high_in, data_low_in};
        page_index_out     <= zpage;
        lock_data_out      <= data_low_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // load redirect, interrupt, boot decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      lpm_special_out  <= 1'b0;
      lpm_fuse_sel_out <= 1'b0;
    end else begin
      lpm_special_out <= lpm_strobe_in & (state_r == spfc_pkg::ST_WINDOW) &
                         (cmd_r == `SPFC_PAT_LOCK) & (win_r >= `SPFC_LPM_MIN_CNT);
      if (lpm_strobe_in) begin
        lpm_fuse_sel_out <= zptr_in[0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      store_ready_irq_out <= 1'b0;
      boot_start_out      <= `SPFC_BOOT_START_0;
    end else begin
      store_ready_irq_out <= ie_r & global_irq_enable_in & ~cmd_r[0];
      boot_start_out      <= boot_start_f(boot_size_select_in);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_arm;
    arm & (state_r == spfc_pkg::ST_IDLE);
  endsequence

  sequence s_quiet;
    (!spm_strobe_in & !wr_pend_r) [*4];
  endsequence

  sequence s_op_start;
    take & ((cmd_r == `SPFC_PAT_PERASE) || (cmd_r == `SPFC_PAT_PWRITE));
  endsequence

  AST_BOOT_DECODE: assert property (
    (boot_size_select_in == 2'h0) [*2] |-> boot_start_out == `SPFC_BOOT_START_0)
    else $error("boot start wrong");

  AST_RSV_ZERO: assert property (
    rd_wait_r & rd_hit_r |=> !hrdata_out[5] && hrdata_out[6] == $past(busy_flag_r))
    else $error("status readback wrong");

  AST_IRQ: assert property (
    ie_r & global_irq_enable_in & !cmd_r[0] |=> store_ready_irq_out)
    else $error("ready interrupt missing");

  AST_BUSY_RWW: assert property (
    s_op_start ##0 in_rww(zpage) |=> busy_flag_r ##1 rww_block_out)
    else $error("region not blocked");

  AST_FILL_CLEAR: assert property (
    take & (cmd_r == `SPFC_PAT_FILL) |=> !busy_flag_r && buf_write_out)
    else $error("fill did not clear busy");

  AST_ABORT: assert property (
    arm & (wdat[4:0] == `SPFC_PAT_REEN) & filling_r |=> buf_discard_out && !filling_r)
    else $error("fill not aborted");

  AST_HALT: assert property (
    s_op_start ##0 !in_rww(zpage) |=> halt_r ##1 (cpu_halt_out && flash_busy_out))
    else $error("core not stalled");

  AST_WINDOW: assert property (
    s_arm ##1 s_quiet |=> cmd_r == 5'h00 && state_r == spfc_pkg::ST_IDLE)
    else $error("window did not expire");

  AST_HOLD: assert property (
    state_r == spfc_pkg::ST_BUSY |-> cmd_r[0] && !arm)
    else $error("store enable dropped during operation");

  AST_BAD_PAT: assert property (
    wr_pend_r & !pat_valid(wdat[4:0]) & (state_r == spfc_pkg::ST_IDLE) |=>
      cmd_r == 5'h00)
    else $error("invalid pattern had effect");

  AST_PROG_LEN: assert property (
    s_op_start |=> (state_r == spfc_pkg::ST_BUSY) [*8])
    else $error("operation ended early");

endmodule // spfc_ctrl

// ==== tb/spfc_core_model.sv ====
`timescale 1ns/100ps

module spfc_core_model (
  // clock
  input  wire logic        clk_sys_in,
  // store and load instructions
  output logic             spm_strobe_out,
  output logic             lpm_strobe_out,
  output logic      [15:0] zptr_out,
  output logic      [7:0]  data_low_out,
  output logic      [7:0]  data_high_out
);
  initial begin
    spm_strobe_out = 1'b0;
    lpm_strobe_out = 1'b0;
    zptr_out       = 16'h5555;
    data_low_out   = 8'h00;
    data_high_out  = 8'h00;
  end

  // --------------------------------
  // instruction issue
  // --------------------------------
  // entered at a clock edge; dly edges pass before the strobe rises
  task automatic spm(input logic [15:0] z, input logic [7:0] lo, input logic [7:0] hi,
                     input int dly);
    repeat (dly) @(posedge clk_sys_in);
    zptr_out       <= {z[15:1], 1'b0};
    data_low_out   <= lo;
    data_high_out  <= hi;
    spm_strobe_out <= 1'b1;
    @(posedge clk_sys_in);
    spm_strobe_out <= 1'b0;
    // stale operands flipped so nothing leans on a held value
    zptr_out       <= ~z;
    data_low_out   <= ~lo;
    data_high_out  <= ~hi;
  endtask

  task automatic lpm(input logic [15:0] z, input int dly);
    repeat (dly) @(posedge clk_sys_in);
    zptr_out       <= z;
    lpm_strobe_out <= 1'b1;
    @(posedge clk_sys_in);
    lpm_strobe_out <= 1'b0;
  endtask
endmodule // spfc_core_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`include "spfc_cfg.svh"

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  localparam logic [31:0] CSR = `SPFC_CSR_BYTE_ADDR;
  logic        clk_sys_in, reset_in, hwrite, gie, hready, hresp;
  logic        irq, halt, lsp, fsel, rwwb, fbusy, bw, bdis, pe, pw, lw, spm, lpm, c_fsel;
  logic [1:0]  htrans, bsz;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] z, bdata, c_bdata;
  logic [7:0]  dl, dh, pidx, ldata, seen, c_pidx, c_ldata;
  logic [5:0]  bidx, c_bidx;
  logic [13:0] bstart;
  logic [7:0]  pats [5] = '{8'h01, 8'h11, 8'h09, 8'h05, 8'h03};
  int          err_count, checked, cycles;

  spfc_ctrl #(.PROG_CYCLES(20), .CNT_W(20)) spfc_ctrl_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .spm_strobe_in(spm), .lpm_strobe_in(lpm), .zptr_in(z), .data_low_in(dl),
    .data_high_in(dh), .global_irq_enable_in(gie), .boot_size_select_in(bsz),
    .store_ready_irq_out(irq), .cpu_halt_out(halt), .lpm_special_out(lsp),
    .lpm_fuse_sel_out(fsel), .rww_block_out(rwwb), .flash_busy_out(fbusy),
    .buf_write_out(bw), .buf_word_index_out(bidx), .buf_data_out(bdata),
    .buf_discard_out(bdis), .page_erase_out(pe), .page_write_out(pw),
    .page_index_out(pidx), .lock_write_out(lw), .lock_data_out(ldata),
    .boot_start_out(bstart));

  spfc_core_model spfc_core_model_inst (
    .clk_sys_in(clk_sys_in), .spm_strobe_out(spm), .lpm_strobe_out(lpm), .zptr_out(z),
    .data_low_out(dl), .data_high_out(dh));

  always #5 clk_sys_in = ~clk_sys_in;

  // --------------------------------
  // pulse capture
  // --------------------------------
  // sticky so that a one-cycle pulse is never missed between checks
  always @(posedge clk_sys_in) begin
    if (bw) begin seen[0] <= 1'b1; c_bidx <= bidx; c_bdata <= bdata; end
    if (bdis) seen[1] <= 1'b1;
    if (pe) seen[2] <= 1'b1;
    if (pw) seen[3] <= 1'b1;
    if (pe | pw) c_pidx <= pidx;
    if (lw) begin seen[4] <= 1'b1; c_ldata <= ldata; end
    if (lsp) begin seen[5] <= 1'b1; c_fsel <= fsel; end
    if (halt) seen[6] <= 1'b1;
    cycles++;
    if (cycles == 20000) begin err_count++; conclude(); end
  end

  // --------------------------------
  // bus tasks
  // --------------------------------
  // waits as long as the slave stalls; only the cycle ceiling ends a hang
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2; haddr <= a; hwrite <= w;
    do begin @(posedge clk_sys_in); end while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge clk_sys_in); end while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] d); ahb(1'b1, CSR, {24'h0, d}); endtask
  task automatic rc(input logic [31:0] a, input logic [7:0] e, input string nm);
    ahb(1'b0, a, 32'h0);
    `CHK(nm, {24'h0, e}, rd)
    `CHK({nm, " resp"}, 1'b0, hresp)
  endtask
  task automatic cyc(input int k); repeat (k) @(posedge clk_sys_in); endtask
  task automatic op_wait;
    cyc(3);
    while (fbusy !== 1'b0) begin @(posedge clk_sys_in); end
    cyc(3);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // --------------------------------
  // test sequence
  // --------------------------------
  initial begin
    clk_sys_in = 0; reset_in = 1; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0;
    gie = 0; bsz = 0; seen = '0; err_count = 0; checked = 0; cycles = 0;
    cyc(12);
    reset_in <= 1'b0;
    rc(CSR, 8'h00, "csr reset");
    rc(32'h0, 8'h00, "unmapped");
    gie <= 1'b1;
    wr(8'hFF); rc(CSR, 8'h80, "csr mask");
    cyc(2); `CHK("irq on", 1'b1, irq)
    wr(8'h81); cyc(2); `CHK("irq store set", 1'b0, irq)
    cyc(6); `CHK("irq expired", 1'b1, irq)
    gie <= 1'b0; cyc(2); `CHK("irq global", 1'b0, irq)
    wr(8'h00);
    foreach (pats[i]) begin wr(pats[i]); cyc(6); rc(CSR, 8'h00, "expiry"); end
    wr(8'h07); spfc_core_model_inst.spm(16'h0000, 8'h11, 8'h22, 0); cyc(2);
    `CHK("bad pattern", 8'h00, seen)
    wr(8'h01); spfc_core_model_inst.spm(16'h0087, 8'h3C, 8'hA5, 0); cyc(2);
    `CHK("fill pulse", 1'b1, seen[0])
    `CHK("fill index", 6'h03, c_bidx)
    `CHK("fill data", 16'hA53C, c_bdata)
    rc(CSR, 8'h00, "fill done");
    wr(8'h03); spfc_core_model_inst.spm(16'h3780, 8'h00, 8'h00, 0); cyc(3);
    rc(CSR, 8'h43, "erase busy");
    `CHK("flash busy", 1'b1, fbusy)
    `CHK("erase page", 8'h6F, c_pidx)
    `CHK("rww block", 1'b1, rwwb)
    wr(8'h11); rc(CSR, 8'h43, "reen refused");
    op_wait(); rc(CSR, 8'h40, "erase done");
    `CHK("no halt rww", 1'b0, seen[6])
    // store enable seen clear before re-enable
    wr(8'h11); spfc_core_model_inst.spm(16'h0000, 8'h00, 8'h00, 0); cyc(2);
    rc(CSR, 8'h00, "reenable");
    `CHK("rww unblock", 1'b0, rwwb)
    // word index zero for page write
    wr(8'h05); spfc_core_model_inst.spm(16'h7000, 8'h00, 8'h00, 0); cyc(3);
    `CHK("halt", 1'b1, halt)
    `CHK("write page", 8'hE0, c_pidx)
    `CHK("write pulse", 1'b1, seen[3])
    op_wait(); `CHK("halt end", 1'b0, halt)
    rc(CSR, 8'h00, "write done");
    seen <= '0;
    wr(8'h09); spfc_core_model_inst.lpm(16'h0001, 0);
    spfc_core_model_inst.spm(16'h0000, 8'h5A, 8'hC3, 1); cyc(2);
    `CHK("lock read", 2'b11, {seen[5], c_fsel})
    `CHK("lock data", 8'h5A, c_ldata)
    op_wait(); rc(CSR, 8'h00, "lock done");
    wr(8'h03); spfc_core_model_inst.spm(16'h0100, 8'h00, 8'h00, 0);
    op_wait(); rc(CSR, 8'h40, "busy kept");
    wr(8'h01); spfc_core_model_inst.spm(16'h0002, 8'h01, 8'h02, 0); cyc(2);
    rc(CSR, 8'h00, "busy by fill");
    wr(8'h11); cyc(2); `CHK("discard", 1'b1, seen[1])
    cyc(6);
    for (int i = 0; i < 4; i++) begin
      bsz <= 2'(i); cyc(3);
      `CHK("boot start", 14'(16'h4000 - (16'h0100 << (3 - i))), bstart)
    end
    conclude();
  end
endmodule // tb_top
